// [tsm_defs.svh]
/*
  constants of the two-wire memory slave front end: bus codes, bit
  counts and buffer sizes. assumes it is included by bare name.
*/
`ifndef TSM_DEFS_SVH
`define TSM_DEFS_SVH

// ----------------------------------------
// slave address layout
// ----------------------------------------
`define TSM_DEV_TYPE      4'ha
`define TSM_MCODE_TOP     5'h01
`define TSM_DEV_TYPE_MSB  7
`define TSM_DEV_TYPE_LSB  4
`define TSM_SEL_MSB       3
`define TSM_SEL_LSB       1
`define TSM_RW_BIT        0

// ----------------------------------------
// bit counting
// ----------------------------------------
`define TSM_CNT_BYTE      4'h8
`define TSM_CNT_LAST      4'h7
`define TSM_CNT_ACK       4'h9
`define TSM_CNT_RESET     4'h0

// ----------------------------------------
// memory address and write buffer
// ----------------------------------------
`define TSM_ADDR_W        15
`define TSM_ADDR_RESET    15'h0000
`define TSM_FIFO_W        23
`define TSM_FIFO_D        8

`endif

// [tsm_pkg.sv]
/*
  types of the two-wire memory slave front end.
  assumes nothing of its surroundings.
*/
package tsm_pkg;

  // ----------------------------------------
  // protocol states, one-hot
  // ----------------------------------------
  typedef enum logic [6:0] {
    TSM_IDLE = 7'h01,
    TSM_SLV  = 7'h02,
    TSM_ADH  = 7'h04,
    TSM_ADL  = 7'h08,
    TSM_WR   = 7'h10,
    TSM_RD   = 7'h20,
    TSM_HOLD = 7'h40
  } tsm_state_t;

endpackage

// [tsm_slave.sv]
/*
  two-wire serial slave front end of a 32k x 8 byte memory, with its
  write buffer. assumes scl and sda come from the pins asynchronously,
  the open-drain wire is resolved outside from sda_oe, and the memory
  array sits outside behind a write handshake and a read port.
*/
`timescale 1ns/100ps

`include "tsm_defs.svh"

// ----------------------------------------
// write buffer
// ----------------------------------------
module tsm_fifo #(
  parameter int W = `TSM_FIFO_W,
  parameter int D = `TSM_FIFO_D
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push, pop;

  assign in_ready  = (cnt_q != (AW + 1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// slave front end
// ----------------------------------------
module tsm_slave
  import tsm_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe,
  input  wire logic [2:0]             device_select_pins,
  input  wire logic                   write_protect,
  output logic                        mem_wr_valid,
  input  wire logic                   mem_wr_ready,
  output logic [`TSM_ADDR_W-1:0]      mem_wr_addr,
  output logic [7:0]                  mem_wr_data,
  output logic [`TSM_ADDR_W-1:0]      mem_rd_addr,
  input  wire logic [7:0]             mem_rd_data,
  output logic                        hs_mode
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0]              scl_q, sda_q, wp_q;
  logic [2:0]              sel_q0, sel_q1;
  logic                    scl_p_q, sda_p_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_q   <= 2'h3;
      sda_q   <= 2'h3;
      wp_q    <= 2'h0;
      sel_q0  <= 3'h0;
      sel_q1  <= 3'h0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_q   <= {scl_q[0], scl_i};
      sda_q   <= {sda_q[0], sda_i};
      wp_q    <= {wp_q[0], write_protect};
      sel_q0  <= device_select_pins;
      sel_q1  <= sel_q0;
      scl_p_q <= scl_q[1];
      sda_p_q <= sda_q[1];
    end
  end

  // ----------------------------------------
  // bus events
  // ----------------------------------------
  logic scl_s, sda_s, scl_rise, scl_fall, cond_start, cond_stop;

  assign scl_s      = scl_q[1];
  assign sda_s      = sda_q[1];
  assign scl_rise   = scl_s && !scl_p_q;
  assign scl_fall   = !scl_s && scl_p_q;
  assign cond_start = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign cond_stop  = scl_s && scl_p_q && !sda_p_q && sda_s;

  // ----------------------------------------
  // byte decode
  // ----------------------------------------
  tsm_state_t              state_q;
  logic [3:0]              cnt_q;
  logic [7:0]              shift_q, rx_byte;
  logic [6:0]              addr_hi_q;
  logic [`TSM_ADDR_W-1:0]  addr_q;
  logic                    ack_q, sda_oe_q, hs_q, byte_done, sel_match;
  logic                    mcode, ack_d, fifo_ready, push;

  assign rx_byte   = {shift_q[6:0], sda_s};
  assign byte_done = scl_rise && (cnt_q == `TSM_CNT_LAST);
  assign sel_match = (rx_byte[`TSM_DEV_TYPE_MSB:`TSM_DEV_TYPE_LSB] == `TSM_DEV_TYPE)
                  && (rx_byte[`TSM_SEL_MSB:`TSM_SEL_LSB] == sel_q1);
  assign mcode     = (rx_byte[7:3] == `TSM_MCODE_TOP);

  always_comb
  begin
    case (state_q)
      TSM_SLV:  ack_d = sel_match;
      TSM_ADH:  ack_d = 1'b1;
      TSM_ADL:  ack_d = 1'b1;
      TSM_WR:   ack_d = !wp_q[1] && fifo_ready;
      default:  ack_d = 1'b0;
    endcase
  end

  assign push = byte_done && (state_q == TSM_WR) && ack_d;

  // ----------------------------------------
  // protocol sequencer
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q  <= TSM_IDLE;
      cnt_q    <= `TSM_CNT_RESET;
      shift_q  <= 8'h00;
      ack_q    <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else if (cond_start || cond_stop)
    begin
      state_q  <= cond_start ? TSM_SLV : TSM_IDLE;
      cnt_q    <= `TSM_CNT_RESET;
      ack_q    <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        TSM_SLV, TSM_ADH, TSM_ADL, TSM_WR:
        begin
          if (scl_rise && cnt_q < `TSM_CNT_BYTE)
          begin
            shift_q <= rx_byte;
            cnt_q   <= cnt_q + 4'h1;
            if (byte_done)
            begin
              ack_q <= ack_d;
            end
          end
          else if (scl_rise && cnt_q == `TSM_CNT_BYTE)
          begin
            cnt_q <= `TSM_CNT_ACK;
          end
          else if (scl_fall && cnt_q == `TSM_CNT_BYTE)
          begin
            sda_oe_q <= ack_q;
          end
          else if (scl_fall && cnt_q == `TSM_CNT_ACK)
          begin
            sda_oe_q <= 1'b0;
            cnt_q    <= `TSM_CNT_RESET;
            if (!ack_q)
            begin
              state_q <= TSM_HOLD;
            end
            else if (state_q == TSM_SLV && shift_q[`TSM_RW_BIT])
            begin
              state_q  <= TSM_RD;
              shift_q  <= mem_rd_data;
              sda_oe_q <= !mem_rd_data[7];
            end
            else
            begin
              state_q <= (state_q == TSM_SLV) ? TSM_ADH
                       : (state_q == TSM_ADH) ? TSM_ADL : TSM_WR;
            end
          end
        end
        TSM_RD:
        begin
          if (scl_rise && cnt_q < `TSM_CNT_BYTE)
          begin
            cnt_q <= cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q > `TSM_CNT_RESET && cnt_q < `TSM_CNT_BYTE)
          begin
            shift_q  <= {shift_q[6:0], 1'b0};
            sda_oe_q <= !shift_q[6];
          end
          else if (scl_fall && cnt_q == `TSM_CNT_BYTE)
          begin
            sda_oe_q <= 1'b0;
          end
          else if (scl_rise && cnt_q == `TSM_CNT_BYTE)
          begin
            ack_q <= !sda_s;
            cnt_q <= `TSM_CNT_ACK;
          end
          else if (scl_fall && cnt_q == `TSM_CNT_ACK)
          begin
            cnt_q <= `TSM_CNT_RESET;
            if (ack_q)
            begin
              shift_q  <= mem_rd_data;
              sda_oe_q <= !mem_rd_data[7];
            end
            else
            begin
              state_q <= TSM_HOLD;
            end
          end
        end
        default:
        begin
          state_q  <= TSM_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // address latch
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_hi_q <= 7'h00;
      addr_q    <= `TSM_ADDR_RESET;
    end
    else if (byte_done && state_q == TSM_ADH)
    begin
      addr_hi_q <= rx_byte[6:0];
    end
    else if (byte_done && state_q == TSM_ADL)
    begin
      addr_q <= {addr_hi_q, rx_byte};
    end
    else if (push || (byte_done && state_q == TSM_RD))
    begin
      addr_q <= addr_q + 15'h0001;
    end
  end

  // ----------------------------------------
  // high speed mode flag
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hs_q <= 1'b0;
    end
    else if (cond_stop)
    begin
      hs_q <= 1'b0;
    end
    else if (byte_done && state_q == TSM_SLV && mcode)
    begin
      hs_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // write buffer toward the array
  // ----------------------------------------
  tsm_fifo #(
    .W (`TSM_FIFO_W),
    .D (`TSM_FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({addr_q, rx_byte}),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready),
    .out_data  ({mem_wr_addr, mem_wr_data})
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sda_o       = 1'b0;
  assign sda_oe      = sda_oe_q;
  assign mem_rd_addr = addr_q;
  assign hs_mode     = hs_q;

endmodule

// [tsm_checker.sv]
/*
  port checks of the two-wire memory slave.
  assumes a bind onto tsm_slave from the bench.
*/
`timescale 1ns/100ps
`include "tsm_defs.svh"

module tsm_checker
  import tsm_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   scl_i,
  input wire logic                   sda_i,
  input wire logic                   sda_o,
  input wire logic                   sda_oe,
  input wire logic                   write_protect,
  input wire logic                   mem_wr_valid,
  input wire logic                   mem_wr_ready,
  input wire logic [`TSM_ADDR_W-1:0] mem_wr_addr,
  input wire logic [7:0]             mem_wr_data,
  input wire logic [`TSM_ADDR_W-1:0] mem_rd_addr,
  input wire logic                   hs_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  reset_quiet_a: assert property ($rose(rst_n) |-> !sda_oe && !mem_wr_valid && !hs_mode
    && mem_rd_addr == `TSM_ADDR_RESET) else $error("outputs busy after reset");
  drain_only_a: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  oe_on_low_a: assert property ($changed(sda_oe) |-> !$past(scl_i, 3))
    else $error("data pin changed with clock high");
  oe_bounded_a: assert property ($rose(sda_oe) |-> ##[1:90] !sda_oe)
    else $error("data pin held too long");
  wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
    && $stable(mem_wr_addr) && $stable(mem_wr_data)) else $error("write dropped");
  wr_protect_a: assert property ($rose(mem_wr_valid) |-> !$past(write_protect, 3))
    else $error("write while protected");
  addr_on_rise_a: assert property ($changed(mem_rd_addr) |-> $past(scl_i, 2))
    else $error("address moved off a clock rise");
  hs_stop_a: assert property (scl_i && $rose(sda_i) |-> ##[1:6] !hs_mode)
    else $error("fast mode kept after stop");
endmodule

// [tsm_master.sv]
/*
  behavioural two-wire bus master, 800 ns bit time.
  assumes a pull-up wire resolved by the bench.
*/
`timescale 1ns/100ps

module tsm_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q(input int n);
    repeat (2 * n) @(negedge clk);
  endtask
  task automatic start();
    sda_low = 1'b0;
    q(1);
    scl = 1'b1;
    q(2);
    sda_low = 1'b1;
    q(2);
    scl = 1'b0;
    q(1);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q(1);
    scl = 1'b1;
    q(2);
    sda_low = 1'b0;
    q(2);
  endtask
  task automatic xbit(input logic b, output logic r);
    sda_low = ~b;
    q(1);
    scl = 1'b1;
    q(1);
    r = sda;
    q(1);
    scl = 1'b0;
    q(1);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(b[i], r);
    xbit(1'b1, r);
    ak = ~r;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(1'b1, r);
      b[i] = r;
    end
    xbit(~more, r);
  endtask
endmodule

// [testbench.sv]
/*
  self-checking bench of the two-wire memory slave.
  assumes tsm_slave, tsm_master and tsm_checker are compiled.
*/
`timescale 1ns/100ps
`include "tsm_defs.svh"

module testbench;
  import tsm_pkg::*;
  logic                   clk, rst_n, scl, sda_low, sda, sda_o, sda_oe;
  logic                   wp, wr_valid, wr_ready, hs;
  logic [2:0]             sel;
  logic [`TSM_ADDR_W-1:0] wr_addr, rd_addr;
  logic [7:0]             wr_data, rd_data;
  logic [7:0]             mem [0:32767];
  int                     failures, total_checks;

  assign sda = ~(sda_low | sda_oe);
  assign rd_data = mem[rd_addr];
  always @(posedge clk) if (wr_valid && wr_ready) mem[wr_addr] <= wr_data;

  tsm_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  tsm_slave dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .device_select_pins(sel), .write_protect(wp),
    .mem_wr_valid(wr_valid), .mem_wr_ready(wr_ready), .mem_wr_addr(wr_addr),
    .mem_wr_data(wr_data), .mem_rd_addr(rd_addr), .mem_rd_data(rd_data), .hs_mode(hs));

  // ----------------------------------------
  // compare and bus helpers
  // ----------------------------------------
  function automatic logic [7:0] ev(input logic [14:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic sb(input logic [7:0] b, input logic ea);
    logic ak;
    m.wbyte(b, ak);
    chk_ack(ak, ea);
  endtask
  task automatic rb(input logic more, input logic [7:0] e);
    logic [7:0] d;
    m.rbyte(more, d);
    chk_val({8'h00, d}, {8'h00, e});
  endtask
  task automatic wa(input logic [15:0] a);
    m.start();
    sb({`TSM_DEV_TYPE, sel, 1'b0}, 1'b1);
    sb(a[15:8], 1'b1);
    sb(a[7:0], 1'b1);
  endtask
  task automatic rd_open();
    m.start();
    sb({`TSM_DEV_TYPE, sel, 1'b1}, 1'b1);
  endtask
  task automatic close_out();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_write_read();
    wa(16'h8123);
    sb(8'ha5, 1'b1);
    sb(8'h3c, 1'b1);
    m.stop();
    wa(16'h8123);
    rd_open();
    rb(1'b1, 8'ha5);
    rb(1'b0, 8'h3c);
    m.stop();
    rd_open();
    rb(1'b0, ev(15'h0125));
    m.stop();
  endtask
  task automatic s_fill_wrap();
    int n;
    wr_ready = 1'b0;
    wa(16'h7ffc);
    for (int i = 0; i < 8; i++) sb(8'hc0 + 8'(i), 1'b1);
    sb(8'hee, 1'b0);
    m.stop();
    wr_ready = 1'b1;
    n = 0;
    while (wr_valid && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk_ack(wr_valid, 1'b0);
    for (int i = 0; i < 8; i++) chk_val({8'h00, mem[15'(32764 + i)]}, 16'h00c0 + 16'(i));
    rd_open();
    rb(1'b0, ev(15'h0004));
    m.stop();
  endtask
  task automatic s_protect();
    wp = 1'b1;
    wa(16'h0200);
    sb(8'h77, 1'b0);
    m.stop();
    wp = 1'b0;
    rd_open();
    rb(1'b0, ev(15'h0200));
    m.stop();
  endtask
  task automatic s_abort();
    logic r;
    wa(16'h0300);
    for (int i = 0; i < 4; i++) m.xbit(1'b0, r);
    m.stop();
    rd_open();
    rb(1'b0, ev(15'h0300));
    m.stop();
  endtask
  task automatic s_select();
    m.start();
    sb({4'h9, sel, 1'b0}, 1'b0);
    sb(8'h00, 1'b0);
    m.stop();
    for (int k = 0; k < 8; k++)
    begin
      m.start();
      sb({`TSM_DEV_TYPE, 3'(k), 1'b0}, 3'(k) == sel);
      m.stop();
    end
  endtask
  task automatic s_fast();
    m.start();
    sb({`TSM_MCODE_TOP, 3'h2}, 1'b0);
    chk_ack(hs, 1'b1);
    m.stop();
    repeat (8) @(negedge clk);
    chk_ack(hs, 1'b0);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (90000) @(negedge clk);
    failures++;
    close_out();
  end
  initial
  begin
    for (int i = 0; i < 32768; i++) mem[i] = ev(15'(i));
    rst_n = 1'b0;
    wp = 1'b0;
    wr_ready = 1'b1;
    sel = 3'h5;
    failures = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    s_write_read();
    s_fill_wrap();
    s_protect();
    s_abort();
    s_select();
    sel = 3'h2;
    s_select();
    s_fast();
    close_out();
  end
endmodule

bind tsm_slave tsm_checker chk (.clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .write_protect(write_protect),
  .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
  .mem_wr_data(mem_wr_data), .mem_rd_addr(mem_rd_addr), .hs_mode(hs_mode));
